// file: src/sssg_pkg.sv
package sssg_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned NUM_OUT = 5;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;

  localparam int unsigned CTRL_MODE_POS = 0;
  localparam int unsigned CTRL_FB_POS = 2;
  localparam int unsigned CTRL_AVG_POS = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  localparam int unsigned STAT_ACTIVE_POS = 0;
  localparam int unsigned STAT_PIN_POS = 1;
  localparam int unsigned STAT_CLKFAIL_POS = 2;
  localparam int unsigned STAT_BLANK_POS = 3;
  localparam int unsigned STAT_SIGN_POS = 4;
  localparam int unsigned STAT_FAULT_POS = 5;

  typedef enum logic [1:0] {
    SSSG_OFF,
    SSSG_VALID,
    SSSG_TRIG_SEL,
    SSSG_TRIG_MID
  } sssg_mode_e;

  localparam logic [2:0] FB_NONE = 3'h0;
  localparam logic [2:0] FB_CUR_FIRST = 3'h1;
  localparam logic [2:0] FB_CUR_LAST = 3'h5;
  localparam logic [2:0] FB_TEMP = 3'h6;
  localparam logic [2:0] FB_SUPPLY = 3'h7;

  localparam int unsigned PRESCALE_DIV = 1024;
  localparam int unsigned PRESCALE_HALF = PRESCALE_DIV / 2;

  localparam real FALLBACK_PERIOD_MS = 6.5;
  localparam int unsigned FALLBACK_HALF_CYC =
    int'(FALLBACK_PERIOD_MS * 1.0e6 / 2.0) / CLK_PERIOD_NS;

  localparam int unsigned HIGH_PULSE_US = 100;
  localparam int unsigned HIGH_PULSE_CYC =
    HIGH_PULSE_US * 1000 / CLK_PERIOD_NS;

  localparam int unsigned TURN_ON_DLY_US = 20;
  localparam int unsigned SETTLE_US = 30;
  localparam int unsigned BLANK_CYC =
    ((TURN_ON_DLY_US + SETTLE_US) * 1000 + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;

  localparam int unsigned PWM_FAIL_US = 200;
  localparam int unsigned PWM_FAIL_CYC =
    PWM_FAIL_US * 1000 / CLK_PERIOD_NS;

endpackage

// file: src/sssg_sync2.sv
module sssg_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] stage1;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

// file: src/sssg_sqwave.sv
module sssg_sqwave #(
  parameter int unsigned HALF = 512
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_run,
  input wire logic i_tick,
  output logic o_wave
);

  logic [31:0] cnt;

  if (HALF < 1) begin : g_chk
    $error("sssg_sqwave: HALF must be at least 1");
  end

  // even halves give the 50 % duty cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_run) begin
      cnt <= 32'h0000_0000;
      o_wave <= 1'b0;
    end else if (i_tick) begin
      if (cnt == 32'(HALF - 1)) begin
        cnt <= 32'h0000_0000;
        o_wave <= ~o_wave;
      end else begin
        cnt <= cnt + 32'h0000_0001;
      end
    end
  end

endmodule

// file: src/sssg_top.sv
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
module sssg_top
  import sssg_pkg::*;
#(
  parameter int unsigned FALLBACK_HALF = FALLBACK_HALF_CYC,
  parameter int unsigned PWM_FAIL = PWM_FAIL_CYC,
  parameter int unsigned PULSE_W = 16
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_normal_mode,
  input wire logic i_pwm_clk,
  input wire logic i_pwm_cycle_start,
  input wire logic [NUM_OUT-1:0] i_out_on,
  input wire logic [NUM_OUT-1:0] i_out_full_duty,
  input wire logic [NUM_OUT-1:0] i_out_fault,
  input wire logic [NUM_OUT-1:0] i_out_enable,
  input wire logic [NUM_OUT-1:0] i_inrush_current_window,
  input wire logic i_sense_sample_strobe_n_in,
  output logic o_sense_sample_strobe_n_out,
  output logic o_sense_sample_strobe_n_oe,
  output logic o_offset_sign
);

  if (PULSE_W < 2 || PULSE_W > 32 || FALLBACK_HALF < 1 || PWM_FAIL < 2
      || HIGH_PULSE_CYC > 4095 || BLANK_CYC > 4095) begin : g_chk
    $error("sssg_top: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm clock pin and strobe pin readback
  logic [1:0] pins_sync;
  logic pwm_s, pwm_s_d, pin_level, pwm_tick;

  sssg_sync2 #(.W(2)) u_sync (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async({i_sense_sample_strobe_n_in, i_pwm_clk}),
    .o_sync(pins_sync)
  );

  assign pwm_s = pins_sync[0];
  assign pin_level = pins_sync[1];
  assign pwm_tick = pwm_s & ~pwm_s_d;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pwm_s_d <= 1'b0;
    end else begin
      pwm_s_d <= pwm_s;
    end
  end

  // pwm clock watchdog: no edge for too long means a clock failure
  logic [31:0] idle_cnt;
  logic clk_fail;

  always_ff @(posedge i_core_clk) begin
    if (i_rst || pwm_tick) begin
      idle_cnt <= 32'h0000_0000;
    end else if (idle_cnt != 32'(PWM_FAIL)) begin
      idle_cnt <= idle_cnt + 32'h0000_0001;
    end
  end

  assign clk_fail = (idle_cnt == 32'(PWM_FAIL));

  ////////////////////////////////////////////////////////////////////////
  // register slave
  sssg_mode_e mode;
  logic [2:0] fb_sel;
  logic avg_mode, wr_take, ctrl_hit, mux_chg, blank_busy;
  logic [NUM_OUT-1:0] fault_lat;
  logic [31:0] rd_mux;

  assign wr_take = i_avs_write & ~o_avs_waitrequest;
  assign ctrl_hit = wr_take && i_avs_address == REG_CTRL
                    && i_avs_byteenable[0];

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (i_avs_address)
      REG_CTRL: begin
        rd_mux[CTRL_MODE_POS +: 2] = mode;
        rd_mux[CTRL_FB_POS +: 3] = fb_sel;
        rd_mux[CTRL_AVG_POS] = avg_mode;
      end
      REG_STATUS: begin
        rd_mux[STAT_ACTIVE_POS] = o_sense_sample_strobe_n_oe;
        rd_mux[STAT_PIN_POS] = pin_level;
        rd_mux[STAT_CLKFAIL_POS] = clk_fail;
        rd_mux[STAT_BLANK_POS] = blank_busy;
        rd_mux[STAT_SIGN_POS] = o_offset_sign;
        rd_mux[STAT_FAULT_POS +: NUM_OUT] = fault_lat;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait cycle, then a single-cycle answer
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata <= i_avs_read ? rd_mux : 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode <= sssg_mode_e'(CTRL_RESET[CTRL_MODE_POS +: 2]);
      fb_sel <= CTRL_RESET[CTRL_FB_POS +: 3];
      avg_mode <= CTRL_RESET[CTRL_AVG_POS];
    end else if (ctrl_hit) begin
      mode <= sssg_mode_e'(i_avs_writedata[CTRL_MODE_POS +: 2]);
      fb_sel <= i_avs_writedata[CTRL_FB_POS +: 3];
      avg_mode <= i_avs_writedata[CTRL_AVG_POS];
    end
  end

  // a new select or averaging setting restarts settling
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mux_chg <= 1'b0;
    end else begin
      mux_chg <= ctrl_hit
        && (i_avs_writedata[CTRL_FB_POS +: 3] != fb_sel
            || i_avs_writedata[CTRL_AVG_POS] != avg_mode);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // selected channel
  logic cur_sel, volt_sel, sel_on, sel_full, sel_fault, sel_inrush;
  logic [2:0] ch;

  assign cur_sel = fb_sel >= FB_CUR_FIRST && fb_sel <= FB_CUR_LAST;
  assign volt_sel = fb_sel == FB_TEMP || fb_sel == FB_SUPPLY;
  assign ch = cur_sel ? fb_sel - FB_CUR_FIRST : 3'h0;
  assign sel_on = cur_sel && i_out_on[ch];
  assign sel_full = cur_sel && i_out_full_duty[ch];
  assign sel_fault = cur_sel && fault_lat[ch];
  assign sel_inrush = cur_sel && i_inrush_current_window[ch];

  logic [NUM_OUT-1:0] en_d;
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_fault
    // fault wins over a re-enable edge in the same cycle
    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        fault_lat[g] <= 1'b0;
        en_d[g] <= 1'b0;
      end else begin
        en_d[g] <= i_out_enable[g];
        if (i_out_fault[g]) begin
          fault_lat[g] <= 1'b1;
        end else if (i_out_enable[g] && !en_d[g]) begin
          fault_lat[g] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // blanking, pulse measurement, trigger waits
  logic sel_on_d, wait_cycle, wait_mid, past_mid;
  logic [11:0] blank_cnt, hp_cnt;
  logic [PULSE_W-1:0] on_cnt, last_len, half_len;

  assign blank_busy = blank_cnt != 12'h000;
  assign half_len = {1'b0, last_len[PULSE_W-1:1]};
  assign past_mid = on_cnt >= half_len;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sel_on_d <= 1'b0;
    end else begin
      sel_on_d <= sel_on;
    end
  end

  // covers switch-on of the output and a new selection
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      blank_cnt <= 12'h000;
    end else if (mux_chg || (sel_on && !sel_on_d)) begin
      blank_cnt <= 12'(BLANK_CYC);
    end else if (blank_busy) begin
      blank_cnt <= blank_cnt - 12'h001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst || mux_chg) begin
      on_cnt <= '0;
      last_len <= '0;
    end else if (sel_on) begin
      if (on_cnt != '1) begin
        on_cnt <= on_cnt + PULSE_W'(1);
      end
    end else begin
      on_cnt <= '0;
      if (sel_on_d) begin
        last_len <= on_cnt;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wait_cycle <= 1'b0;
    end else if (mux_chg) begin
      wait_cycle <= 1'b1;
    end else if (i_pwm_cycle_start) begin
      wait_cycle <= 1'b0;
    end
  end

  // the first pulse after a change is only measured
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wait_mid <= 1'b0;
    end else if (mux_chg) begin
      wait_mid <= 1'b1;
    end else if (sel_on && last_len != '0 && on_cnt == half_len) begin
      wait_mid <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      hp_cnt <= 12'h000;
    end else if (i_pwm_cycle_start) begin
      hp_cnt <= 12'(HIGH_PULSE_CYC);
    end else if (hp_cnt != 12'h000) begin
      hp_cnt <= hp_cnt - 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // square waves
  logic ps_wave, fb_wave;

  sssg_sqwave #(.HALF(PRESCALE_HALF)) u_presc_wave (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run(volt_sel && !clk_fail),
    .i_tick(pwm_tick),
    .o_wave(ps_wave)
  );

  sssg_sqwave #(.HALF(FALLBACK_HALF)) u_fallback_wave (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_run(clk_fail),
    .i_tick(1'b1),
    .o_wave(fb_wave)
  );

  ////////////////////////////////////////////////////////////////////////
  // strobe decision
  logic next_active, valid, trig_mode;

  assign valid = sel_on && !blank_busy;
  assign trig_mode = mode == SSSG_TRIG_SEL || mode == SSSG_TRIG_MID;

  always_comb begin
    next_active = 1'b0;
    if (i_normal_mode && mode != SSSG_OFF) begin
      if (clk_fail && (cur_sel || volt_sel)) begin
        next_active = ~fb_wave;
      end else if (volt_sel) begin
        next_active = ~ps_wave;
      end else if (cur_sel && !sel_fault && !sel_inrush) begin
        if (sel_full && trig_mode) begin
          next_active = hp_cnt == 12'h000;
        end else begin
          unique case (mode)
            SSSG_OFF: next_active = 1'b0;
            SSSG_VALID: next_active = valid;
            SSSG_TRIG_SEL: next_active = valid && !wait_cycle;
            SSSG_TRIG_MID: next_active = valid && past_mid
                                         && !wait_mid;
          endcase
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_sense_sample_strobe_n_oe <= 1'b0;
      o_sense_sample_strobe_n_out <= 1'b0;
    end else begin
      o_sense_sample_strobe_n_oe <= next_active;
      o_sense_sample_strobe_n_out <= 1'b0;
    end
  end

  // pin rises when the pull-down is released
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_offset_sign <= 1'b0;
    end else if (avg_mode && o_sense_sample_strobe_n_oe && !next_active) begin
      o_offset_sign <= ~o_offset_sign;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  a_normal_only: assert property (
    !i_normal_mode |=> !o_sense_sample_strobe_n_oe)
    else $error("strobe driven outside normal mode");
  a_drain_never_high: assert property (
    o_sense_sample_strobe_n_out == 1'b0)
    else $error("strobe pin driven high");
  a_off_mode_idle: assert property (
    mode == SSSG_OFF |=> !o_sense_sample_strobe_n_oe)
    else $error("strobe active in off mode");
  a_inrush_quiet: assert property (
    sel_inrush && !clk_fail |=> !o_sense_sample_strobe_n_oe)
    else $error("strobe active during inrush window");
  a_offphase_quiet: assert property (
    cur_sel && !sel_on && !clk_fail |=> !o_sense_sample_strobe_n_oe)
    else $error("strobe active during pwm off phase");
  a_blank_after_sel: assert property (
    mux_chg && cur_sel && !clk_fail && !sel_full ##1 !clk_fail
      |=> !o_sense_sample_strobe_n_oe [*8])
    else $error("strobe not blanked after select change");
  a_fault_silent: assert property (
    sel_fault && !clk_fail |=> !o_sense_sample_strobe_n_oe)
    else $error("strobe active after output fault");
  a_full_high_pulse: assert property (
    i_pwm_cycle_start && sel_full && trig_mode && i_normal_mode
      && !sel_fault && !sel_inrush && !clk_fail ##1 (sel_full
      && !clk_fail && !sel_inrush && !sel_fault)
      |=> !o_sense_sample_strobe_n_oe)
    else $error("no high pulse at full duty cycle start");
  a_sign_flip: assert property (
    $past(avg_mode) && $fell(o_sense_sample_strobe_n_oe)
      |-> o_offset_sign != $past(o_offset_sign))
    else $error("offset sign not flipped on strobe rise");
  c_mid_pulse: cover property (
    mode == SSSG_TRIG_MID && $rose(o_sense_sample_strobe_n_oe));
  c_fallback: cover property (clk_fail && o_sense_sample_strobe_n_oe);
  c_volt_wave: cover property (
    volt_sel && $fell(o_sense_sample_strobe_n_oe));

endmodule

// file: testbench/sssg_adc_model.sv
module sssg_adc_model (
  input wire logic i_core_clk,
  input wire logic i_strobe_oe,
  input wire logic i_strobe_out,
  output logic o_pin,
  output int o_samples
);
  timeunit 1ns;
  timeprecision 1ns;
  // board pull-up gives the high level; the device only sinks
  assign o_pin = (i_strobe_oe && i_strobe_out === 1'b0) ? 1'b0 : 1'b1;
  initial o_samples = 0;
  // feedback is converted only while the strobe is low
  always @(posedge i_core_clk) begin
    if (o_pin === 1'b0) o_samples <= o_samples + 1;
  end
endmodule

// file: testbench/tb.sv
module tb import sssg_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FBH = 20;
  localparam int LIMIT = 90000;
  logic clk, rst = 1'b1, rd = 1'b0, wr = 1'b0, wait_r;
  logic [3:0] addr = 4'h0, be = 4'hf;
  logic [31:0] wdata = 32'h0000_0000, rdata, q;
  logic [NUM_OUT-1:0] on = '0, full = '0, flt = '0, en = '1, inr = '0;
  logic nrm = 1'b0, pwm = 1'b0, cst = 1'b0, run = 1'b0;
  logic oe, sout, sign, pin, s0;
  logic [1:0] pdiv = 2'h0;
  int error_cnt = 0, n_checks = 0, cyc = 0, samples, p, k;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  sssg_top #(.FALLBACK_HALF(FBH), .PWM_FAIL(50)) dut (
    .i_core_clk(clk), .i_rst(rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_r), .i_normal_mode(nrm), .i_pwm_clk(pwm),
    .i_pwm_cycle_start(cst), .i_out_on(on), .i_out_full_duty(full),
    .i_out_fault(flt), .i_out_enable(en), .i_inrush_current_window(inr),
    .i_sense_sample_strobe_n_in(pin), .o_sense_sample_strobe_n_out(sout),
    .o_sense_sample_strobe_n_oe(oe), .o_offset_sign(sign));

  sssg_adc_model adc (.i_core_clk(clk), .i_strobe_oe(oe),
    .i_strobe_out(sout), .o_pin(pin), .o_samples(samples));

  ////////////////////////////////////////////////////////////////////////
  // pwm clock: period of four core cycles while running
  always @(posedge clk) begin
    pdiv <= pdiv + 2'h1;
    if (run && pdiv[0]) pwm <= ~pwm;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= d;
    @(posedge clk);
    while (wait_r !== 1'b0) @(posedge clk);
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] m,
                                      input logic [2:0] f, input logic a);
    return (32'(m) << CTRL_MODE_POS) | (32'(f) << CTRL_FB_POS)
           | (32'(a) << CTRL_AVG_POS);
  endfunction

  // rise-to-rise period of the strobe in core cycles
  task automatic per(output int n);
    while (oe !== 1'b0) @(posedge clk);
    while (oe !== 1'b1) @(posedge clk);
    n = 0;
    do begin @(posedge clk); n++; end while (oe !== 1'b0);
    do begin @(posedge clk); n++; end while (oe !== 1'b1);
  endtask

  function automatic logic near(input int got, input int exp);
    return got >= exp - 2 && got <= exp + 2;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hbdf0_5788));
    wt(20);
    rst <= 1'b0;
    wt(1);
    bus(1'b0, REG_CTRL, 32'h0000_0000, q);
    chk(q, 32'(CTRL_RESET), "ctrl reset");
    chk(oe, 1'b0, "strobe after reset");
    bus(1'b1, 4'hc, $urandom, q);
    bus(1'b0, 4'hc, 32'h0000_0000, q);
    chk(q, 32'h0000_0000, "unmapped read");
    be <= 4'he;
    bus(1'b1, REG_CTRL, 32'h0000_0003, q);
    be <= 4'hf;
    bus(1'b0, REG_CTRL, 32'h0000_0000, q);
    chk(q, 32'(CTRL_RESET), "lane 0 disabled write");
    run <= 1'b1;
    nrm <= 1'b1;
    on <= 5'h01;
    bus(1'b1, REG_CTRL, ctl(SSSG_OFF, FB_CUR_FIRST, 1'b0), q);
    wt(1400);
    chk(oe, 1'b0, "mode off");
    bus(1'b1, REG_CTRL, ctl(SSSG_VALID, FB_CUR_FIRST, 1'b0), q);
    on <= 5'h00;
    wt(3);
    chk(oe, 1'b0, "off phase");
    on <= 5'h01;
    wt(10);
    chk(oe, 1'b0, "blank after turn on");
    wt(1300);
    chk(oe, 1'b1, "valid window");
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk(q[STAT_PIN_POS], 1'b0, "pin pulled low");
    on <= 5'h00;
    wt(3);
    chk(sign, 1'b0, "sign without averaging");
    on <= 5'h01;
    nrm <= 1'b0;
    wt(1300);
    chk(oe, 1'b0, "not normal mode");
    nrm <= 1'b1;
    inr <= 5'h01;
    wt(1300);
    chk(oe, 1'b0, "inrush window");
    inr <= 5'h00;
    en <= 5'h00;
    flt <= 5'h01;
    wt(1);
    flt <= 5'h00;
    wt(1300);
    chk(oe, 1'b0, "fault latched");
    en <= 5'h1f;
    wt(1300);
    chk(oe, 1'b1, "re-enabled");
    bus(1'b1, REG_CTRL, ctl(SSSG_VALID, FB_CUR_FIRST, 1'b1), q);
    wt(10);
    chk(oe, 1'b0, "blank after averaging switch");
    wt(1300);
    s0 = sign;
    on <= 5'h00;
    wt(3);
    chk(sign, !s0, "offset sign flip");
    chk(32'(samples > 0), 32'h1, "samples taken");
    for (int i = 0; i < 6; i++) begin
      k = $urandom_range(4, 0);
      bus(1'b1, REG_CTRL, ctl(SSSG_VALID, 3'(k + 1), 1'b0), q);
      on <= 5'($urandom);
      wt(1300);
      chk(oe, on[k], "random channel");
    end
    on <= 5'h01;
    bus(1'b1, REG_CTRL, ctl(SSSG_TRIG_SEL, FB_CUR_FIRST, 1'b0), q);
    wt(1300);
    chk(oe, 1'b0, "wait for pwm cycle");
    cst <= 1'b1;
    wt(1);
    cst <= 1'b0;
    wt(5);
    chk(oe, 1'b1, "after pwm cycle");
    full <= 5'h01;
    for (int m = 2; m < 4; m++) begin
      bus(1'b1, REG_CTRL, ctl(2'(m), FB_CUR_FIRST, 1'b0), q);
      wt(1300);
      cst <= 1'b1;
      wt(1);
      cst <= 1'b0;
      wt(10);
      chk(oe, 1'b0, "full duty high pulse");
      wt(HIGH_PULSE_CYC);
      chk(oe, 1'b1, "full duty low");
    end
    full <= 5'h00;
    // first pulse after a select change is only measured
    on <= 5'h00;
    bus(1'b1, REG_CTRL, ctl(SSSG_TRIG_MID, 3'h2, 1'b0), q);
    for (int j = 0; j < 2; j++) begin
      on <= 5'h02;
      wt(1400);
      chk(oe, 1'b0, "before midpoint");
      wt(600);
      chk(oe, 32'(j), "past midpoint");
      wt(1000);
      on <= 5'h00;
      wt(100);
    end
    for (int f = 6; f < 8; f++) begin
      bus(1'b1, REG_CTRL, ctl(SSSG_VALID, 3'(f), 1'b0), q);
      per(p);
      chk(near(p, PRESCALE_DIV * 4), 1'b1, "voltage period");
    end
    run <= 1'b0;
    wt(100);
    bus(1'b0, REG_STATUS, 32'h0000_0000, q);
    chk(q[STAT_CLKFAIL_POS], 1'b1, "clock fail flag");
    per(p);
    chk(near(p, 2 * FBH), 1'b1, "voltage fallback");
    bus(1'b1, REG_CTRL, ctl(SSSG_VALID, FB_CUR_FIRST, 1'b0), q);
    per(p);
    chk(near(p, 2 * FBH), 1'b1, "current fallback");
    bus(1'b1, REG_CTRL, ctl(SSSG_OFF, FB_CUR_FIRST, 1'b0), q);
    wt(5);
    chk(oe, 1'b0, "mode off overrides");
    end_sim();
  end
endmodule
